// >>> tb_wol_detect.sv
// Purpose: Self-checking bench for the wake-on-LAN detector.
// Assumes: Host register port with read data one cycle after the strobe.
// Notes:   Reads and wake probes queue their expectations for one monitor.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_wol_detect;
  import wol_pkg::*;
  logic       clk, rst_b, wr, rd, link, b16, led_src, prb, rd_q, prb_q;
  logic [1:0] led_m;
  logic [7:0] addr, wdata, got, ex;
  logic [7:0] par [6];
  logic [7:0] pat [5];
  logic [1:0] cd [8] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
  logic [7:0] expq [$];
  logic [7:0] frm [$];
  wire logic       rx_v, rx_s, rx_e, rx_b, rx_ok, wake, led;
  wire logic [7:0] rx_d, rdata;
  int         bad_count, n_checks;
  wol_rx_src u_src (.core_clk_i(clk), .rx_valid_o(rx_v), .rx_sof_o(rx_s), .rx_eof_o(rx_e),
    .rx_data_o(rx_d), .rx_bcast_o(rx_b), .rx_ok_o(rx_ok));
  wol_detect dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_valid_i(rx_v), .rx_sof_i(rx_s),
    .rx_eof_i(rx_e), .rx_data_i(rx_d), .rx_bcast_i(rx_b), .rx_ok_i(rx_ok), .phy_link_i(link),
    .led_mode_i(led_m), .bus16_mode_i(b16), .second_led_src_i(led_src), .wake_o(wake),
    .second_led_output_o(led));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask
  // The wake level holds until cleared, so a settled probe is safe.
  task automatic probe(input logic [1:0] e);
    repeat (10) @(posedge clk);
    expq.push_back({6'h00, e});
    prb <= 1'b1;
    @(posedge clk);
    prb <= 1'b0;
  endtask
  task automatic memw(input logic [15:0] a, input logic [7:0] d);
    wr8(WOL_IDX_WPL, a[7:0]);
    wr8(WOL_IDX_WPH, a[15:8]);
    wr8(WOL_IDX_MWC, d);
  endtask
  task automatic magic(input int n);
    frm = {};
    repeat (6) frm.push_back(WOL_SYNC_BYTE);
    repeat (n) for (int j = 0; j < 6; j++) frm.push_back(par[j]);
  endtask
  task automatic toggle_link();
    @(posedge clk);
    link <= ~link;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_q  <= rd;
    prb_q <= prb;
  end
  always @(negedge clk) begin
    if (rd_q || prb_q) begin
      got = rd_q ? rdata : {6'h00, led, wake};
      ex  = expq.pop_front();
      `CHK(got, ex)
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #800000;
    bad_count++;
    stop_test();
  end
  initial begin
    {rst_b, wr, rd, prb, link, b16, led_m, addr, wdata} = '0;
    led_src = 1'b1;
    void'($urandom(64877));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd8(WOL_IDX_NCR, 8'h00);
    rd8(WOL_IDX_IMR, WOL_RST_IMR);
    rd8(WOL_IDX_WST, 8'h00);
    rd8(8'h40, 8'h00);
    for (int i = 0; i < 6; i++) begin
      par[i] = 8'($urandom);
      wr8(WOL_IDX_PAR0 + 8'(i), par[i]);
      rd8(WOL_IDX_PAR0 + 8'(i), par[i]);
    end
    wr8(WOL_IDX_WCR, 8'hFF);
    rd8(WOL_IDX_WCR, 8'h38);
    wr8(WOL_IDX_WCR, 8'h08);
    wr8(WOL_IDX_RCR, 8'h01);
    magic(15);
    u_src.send(frm, 1'b1, 1'b1);
    probe(2'b10);
    magic(16);
    u_src.send(frm, 1'b0, 1'b1);
    probe(2'b10);
    u_src.send(frm, 1'b1, 1'b1);
    probe(2'b10);
    rd8(WOL_IDX_WST, 8'h01);
    wr8(WOL_IDX_NCR, 8'h40);
    probe(2'b11);
    wr8(WOL_IDX_WST, 8'h01);
    probe(2'b10);
    u_src.send(frm, 1'b1, 1'b1);
    probe(2'b11);
    wr8(WOL_IDX_NCR, 8'h00);
    probe(2'b10);
    wr8(WOL_IDX_WST, 8'h01);
    wr8(WOL_IDX_NCR, 8'h40);
    wr8(WOL_IDX_WCR, 8'h20);
    toggle_link();
    probe(2'b11);
    rd8(WOL_IDX_WST, 8'h04);
    wr8(WOL_IDX_WST, 8'h04);
    led_src <= 1'b0;
    led_m   <= WOL_LED_WAKE;
    b16     <= 1'b1;
    probe(2'b00);
    toggle_link();
    probe(2'b10);
    wr8(WOL_IDX_WST, 8'h04);
    led_m   <= 2'h0;
    led_src <= 1'b1;
    probe(2'b10);
    wr8(WOL_IDX_RCR, 8'h00);
    wr8(WOL_IDX_IMR, 8'h00);
    rd8(WOL_IDX_IMR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      if (k < 5) pat[k] = 8'($urandom);
      if (k < 5) memw(16'(4 * k + 2), pat[k]);
      memw(16'(16'h2000 + 4 * k), {2'h0, cd[k], 4'h0});
      memw(16'(16'h2000 + 4 * k + 1), 8'h00);
    end
    wr8(WOL_IDX_WCR, 8'h10);
    wr8(WOL_IDX_RCR, 8'h01);
    for (int c = 0; c < 4; c++) begin
      frm = {};
      for (int k = 0; k < 6; k++) frm.push_back(k < 5 ? pat[k] : 8'h5A);
      if (c == 1) frm[1] = ~frm[1];
      if (c == 1) frm[5] = ~frm[5];
      if (c == 2) frm[3] = ~frm[3];
      if (c == 3) frm = frm[0:3];
      u_src.send(frm, 1'b0, 1'b1);
      probe({1'b1, c < 2});
      if (c < 2) rd8(WOL_IDX_WST, 8'h02);
      if (c < 2) wr8(WOL_IDX_WST, 8'h02);
    end
    stop_test();
  end
endmodule
`default_nettype wire

// >>> wol_detect.sv
// What this block does
// R1: With magic wake on, broadcast frame with sync run plus 16 address copies wakes.
// R2: Magic address compared is the six station address bytes at 10H to 15H.
// R3: Host enables magic wake with bit value 08h of the wake control register.
// R4: Nothing wakes unless the global wake enable, bit 6 of index 00, is set.
// R5: With link wake on (bit value 20h), any link status change wakes.
// R6: Sample wake supports up to six patterns of at most 2048 bytes each.
// R7: A frame matching one loaded pattern under its byte conditions wakes.
// R8: Host disables the receiver (index 05 bit 0) before loading patterns.
// R9: Host clears pointer auto return, bit 7 of index FFH, before loading.
// R10: Patterns 0 to 3 sit in lanes 0 to 3, byte k at word k.
// R11: From 2000h lanes 0,1 hold condition bytes, lanes 2,3 hold patterns 4,5.
// R12: Condition byte 0 covers patterns 0 to 3, byte 1 covers 4 and 5.
// R13: Condition 00/01 ignore, 10 must equal, 11 ends comparison for that pattern.
// R14: Host enables sample wake with bit 4 of the wake control register.
// R15: Host then re-enables the receiver with bit 0 of index 05.
// R16: Wake goes to the wake pin, or to the second LED when configured 10; the code routes it there only in 16-bit bus mode.
// R17: Host loads each byte via write pointer registers then the write command.
// R18: Condition pair for lane position i lies in bits 2i+1 down to 2i.
// R19: Wake stays asserted until its event status or global enable is cleared.
//
// Purpose: Wake-on-LAN detector on the MAC receive path.
// Assumes: Receive bytes arrive on the core clock; config and link are asynchronous.
// Notes:   Frame events are judged one cycle after the last byte is seen.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module wol_detect
  import wol_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       rx_valid_i,
  input  wire logic       rx_sof_i,
  input  wire logic       rx_eof_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_bcast_i,
  input  wire logic       rx_ok_i,
  input  wire logic       phy_link_i,
  input  wire logic [1:0] led_mode_i,
  input  wire logic       bus16_mode_i,
  input  wire logic       second_led_src_i,
  output logic            wake_o,
  output logic            second_led_output_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]      network_control_reg;
    logic [7:0]      receive_control_reg;
    logic [2:0]      wen;
    logic [2:0]      evt;
    logic [5:0][7:0] par;
    logic [7:0]      interrupt_mask_reg;
    logic [7:0]      wpl;
    logic [7:0]      wph;
    logic [7:0]      rdata;
    logic [1:0]      link_s;
    logic            link_prev;
    logic [1:0]      mode_s1;
    logic [1:0]      mode_s2;
    logic [1:0]      b16_s;
    logic            s1_v;
    logic            s1_sof;
    logic            s1_eof;
    logic            s1_ok;
    logic            s1_bc;
    logic            s1_cmp;
    logic [7:0]      s1_b;
    logic [11:0]     idx;
    wol_magic_e      mg_st;
    logic [2:0]      sync_cnt;
    logic [2:0]      byte_idx;
    logic [3:0]      copy_cnt;
    logic            mg_hit;
    logic [5:0]      alive;
    logic [5:0]      done;
    logic            wake;
    logic            wake_pin;
    logic            led;
  } wol_state_s;

  wol_state_s q;
  wol_state_s d;

  logic [31:0]     ra_data;
  logic [31:0]     rb_data;
  logic [11:0]     k_cur;
  logic [15:0]     wptr;
  logic            mem_we;
  logic [5:0]      a0;
  logic [5:0]      d0;
  logic [5:0]      nalive;
  logic [5:0]      ndone;
  logic [5:0][7:0] pat;
  logic [5:0][1:0] code;
  logic [2:0]      evt_set;
  logic [2:0]      evt_clr;
  logic            led_route;
  wol_magic_e      st;
  logic [2:0]      sc;
  logic [2:0]      bi;
  logic [3:0]      cc;
  logic            hit;

  assign wptr   = {q.wph, q.wpl};
  assign mem_we = reg_wr_i && (reg_addr_i == WOL_IDX_MWC);                   // [R17]
  assign k_cur  = rx_sof_i ? 12'h000 : q.idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Pattern memory

  // Word k holds pattern byte k of packets 0..3; word 800h+k holds conditions and 4..5.
  wol_sram u_sram (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .wr_en_i    (mem_we),
    .wr_word_i  (wptr[13:2]),
    .wr_lane_i  (wptr[1:0]),
    .wr_byte_i  (reg_wdata_i),
    .ra_addr_i  (k_cur),                                                     // [R10]
    .ra_data_o  (ra_data),
    .rb_addr_i  (WOL_COND_WORD + k_cur),                                     // [R11]
    .rb_data_o  (rb_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pattern comparison

  generate
    for (genvar p = 0; p < WOL_NPKT; p++) begin : g_pkt
      if (p < 4) begin : g_lo
        assign pat[p]  = ra_data[8*p +: 8];                                  // [R10]
        assign code[p] = rb_data[2*p +: 2];                                  // [R12] [R18]
      end else begin : g_hi
        assign pat[p]  = rb_data[8*p - 16 +: 8];                             // [R11]
        assign code[p] = rb_data[8 + 2*(p-4) +: 2];                          // [R12] [R18]
      end
      assign a0[p] = q.s1_sof ? 1'b1 : q.alive[p];
      assign d0[p] = q.s1_sof ? 1'b0 : q.done[p];
      // Codes 00 and 01 fall through as don't care.
      assign nalive[p] = a0[p] & (d0[p] | ~q.s1_cmp | (code[p] != WOL_COND_EQUAL) |
                                  (q.s1_b == pat[p]));                       // [R13]
      assign ndone[p]  = d0[p] | (a0[p] & q.s1_cmp & (code[p] == WOL_COND_STOP)); // [R13]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d       = q;
    d.rdata = WOL_RST_BYTE;
    evt_set = 3'h0;
    evt_clr = 3'h0;
    st      = q.mg_st;
    sc      = q.sync_cnt;
    bi      = q.byte_idx;
    cc      = q.copy_cnt;
    hit     = q.mg_hit;

    // Register reads answer in the following cycle.
    if (reg_rd_i) begin
      case (reg_addr_i)
        WOL_IDX_NCR: d.rdata = q.network_control_reg;
        WOL_IDX_RCR: d.rdata = q.receive_control_reg;
        WOL_IDX_WCR: d.rdata = {2'h0, q.wen, q.evt};
        WOL_IDX_WST: d.rdata = {5'h00, q.evt};
        WOL_IDX_IMR: d.rdata = q.interrupt_mask_reg;
        WOL_IDX_WPL: d.rdata = q.wpl;
        WOL_IDX_WPH: d.rdata = q.wph;
        default: begin
          if (reg_addr_i >= WOL_IDX_PAR0 && reg_addr_i <= WOL_IDX_PAR5) begin
            d.rdata = q.par[3'(reg_addr_i - WOL_IDX_PAR0)];
          end
        end
      endcase
    end

    if (reg_wr_i) begin
      case (reg_addr_i)
        WOL_IDX_NCR: d.network_control_reg = reg_wdata_i;
        WOL_IDX_RCR: d.receive_control_reg = reg_wdata_i;
        WOL_IDX_WCR: d.wen = reg_wdata_i[WOL_WCR_LINK_EN:WOL_WCR_MAGIC_EN];
        WOL_IDX_WST: evt_clr = reg_wdata_i[2:0];
        WOL_IDX_IMR: d.interrupt_mask_reg = reg_wdata_i;
        WOL_IDX_WPL: d.wpl = reg_wdata_i;
        WOL_IDX_WPH: d.wph = reg_wdata_i;
        // Auto increment lets a run of bytes load without rewriting the pointer.
        WOL_IDX_MWC: d.wpl = 8'(wptr + 16'h0001);
        default: begin
          if (reg_addr_i >= WOL_IDX_PAR0 && reg_addr_i <= WOL_IDX_PAR5) begin
            d.par[3'(reg_addr_i - WOL_IDX_PAR0)] = reg_wdata_i;
          end
        end
      endcase
      if (reg_addr_i == WOL_IDX_MWC) begin
        d.wph = 8'((wptr + 16'h0001) >> 8);
      end
    end

    // Asynchronous inputs pass two flops before use.
    d.link_s    = {q.link_s[0], phy_link_i};
    d.link_prev = q.link_s[1];
    d.mode_s1   = led_mode_i;
    d.mode_s2   = q.mode_s1;
    d.b16_s     = {q.b16_s[0], bus16_mode_i};
    if (q.wen[WOL_WCR_LINK_EN - WOL_WCR_MAGIC_EN] && (q.link_s[1] != q.link_prev)) begin
      evt_set[WOL_EVT_LINK] = 1'b1;                                          // [R5]
    end

    // Receive bytes are taken only while the receiver is on.
    d.s1_v   = rx_valid_i & q.receive_control_reg[WOL_RCR_RX_EN];
    d.s1_sof = rx_sof_i;
    d.s1_eof = rx_eof_i;
    d.s1_ok  = rx_ok_i;
    d.s1_bc  = rx_bcast_i;
    d.s1_b   = rx_data_i;
    d.s1_cmp = k_cur < WOL_PKT_BYTES;                                        // [R6]
    if (d.s1_v && d.s1_cmp) begin
      d.idx = k_cur + 12'h001;
    end else if (d.s1_v) begin
      d.idx = k_cur;
    end

    if (q.s1_v) begin
      if (q.s1_sof) begin
        st  = WOL_MG_HUNT;
        sc  = 3'h0;
        bi  = 3'h0;
        cc  = 4'h0;
        hit = 1'b0;
      end
      // Sync run of six all-ones bytes, then sixteen copies of the address.
      if (st == WOL_MG_ADDR) begin
        if (q.s1_b == q.par[bi]) begin                                       // [R2]
          if (bi == WOL_ADDR_LAST) begin
            bi = 3'h0;
            if (cc == WOL_COPY_LAST) begin
              hit = 1'b1;                                                    // [R1]
              st  = WOL_MG_HUNT;
              sc  = 3'h0;
              cc  = 4'h0;
            end else begin
              cc = cc + 4'h1;
            end
          end else begin
            bi = bi + 3'h1;
          end
        end else if (!(q.s1_b == WOL_SYNC_BYTE && bi == 3'h0 && cc == 4'h0)) begin
          st = WOL_MG_HUNT;
          bi = 3'h0;
          cc = 4'h0;
          sc = (q.s1_b == WOL_SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end else if (q.s1_b == WOL_SYNC_BYTE) begin
        if (sc == WOL_SYNC_LAST) begin
          st = WOL_MG_ADDR;
        end else begin
          sc = sc + 3'h1;
        end
      end else begin
        sc = 3'h0;
      end
      d.mg_st    = st;
      d.sync_cnt = sc;
      d.byte_idx = bi;
      d.copy_cnt = cc;
      d.mg_hit   = hit;
      d.alive    = nalive;
      d.done     = ndone;
      if (q.s1_eof && q.s1_ok) begin
        if (hit && q.s1_bc && q.wen[0]) begin
          evt_set[WOL_EVT_MAGIC] = 1'b1;                                     // [R1]
        end
        if ((|ndone) && q.wen[WOL_WCR_SAMPLE_EN - WOL_WCR_MAGIC_EN]) begin
          evt_set[WOL_EVT_SAMPLE] = 1'b1;                                    // [R7]
        end
      end
    end

    // A new event wins over a clear in the same cycle.
    d.evt  = (q.evt & ~evt_clr) | evt_set;                                   // [R19]
    d.wake = q.network_control_reg[WOL_NCR_WAKE_EN] & (|d.evt);                              // [R4] [R19]

    led_route  = (q.mode_s2 == WOL_LED_WAKE) && q.b16_s[1];
    d.wake_pin = d.wake & ~led_route;                                        // [R16]
    d.led      = led_route ? d.wake : second_led_src_i;                      // [R16]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q     <= '0;
      q.interrupt_mask_reg <= WOL_RST_IMR;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o         = q.rdata;
  assign wake_o              = q.wake_pin;
  assign second_led_output_o = q.led;

endmodule
`default_nettype wire

// >>> wol_detect_checker.sv
// Purpose: Port-level checks for the wake-on-LAN detector.
// Assumes: Register shadows follow the host's writes.
// Notes:   Bound into every detector instance.
`timescale 1ns/10ps
`default_nettype none
module wol_detect_checker
  import wol_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       rx_valid_i,
  input wire logic       rx_eof_i,
  input wire logic       phy_link_i,
  input wire logic [1:0] led_mode_i,
  input wire logic       bus16_mode_i,
  input wire logic       second_led_src_i,
  input wire logic       wake_o,
  input wire logic       second_led_output_o
);
  logic [7:0] par_q [6];
  logic [7:0] exp_q;
  logic [2:0] wcr_q;
  logic [2:0] cfg_q;
  logic       ncr6_q;
  logic       imr7_q;
  logic       link_q;
  logic [3:0] age_q;
  logic [3:0] clr_q;
  wire        routed  = led_mode_i == WOL_LED_WAKE && bus16_mode_i;
  wire        led_chg = {led_mode_i, bus16_mode_i} != cfg_q;
  wire        ncr_w   = reg_wr_i && reg_addr_i == WOL_IDX_NCR;
  wire        par_a   = reg_addr_i[7:3] == 5'h02 && reg_addr_i[2:0] < 3'h6;
  wire        cause   = led_chg || ncr_w || phy_link_i != link_q || rx_valid_i && rx_eof_i;
  //////////////////////////////////////////////////////////////////////////////
  // Ages are saturating counts of cycles since the last possible cause of a wake change.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      par_q  <= '{default: 8'h00};
      exp_q  <= 8'h00;
      wcr_q  <= 3'h0;
      cfg_q  <= 3'h0;
      ncr6_q <= 1'b0;
      imr7_q <= 1'b1;
      link_q <= 1'b0;
      age_q  <= 4'hF;
      clr_q  <= 4'hF;
    end else begin
      cfg_q  <= {led_mode_i, bus16_mode_i};
      link_q <= phy_link_i;
      exp_q  <= par_q[reg_addr_i[2:0]];
      if (ncr_w) ncr6_q <= reg_wdata_i[WOL_NCR_WAKE_EN];
      if (reg_wr_i && reg_addr_i == WOL_IDX_WCR) wcr_q <= reg_wdata_i[5:3];
      if (reg_wr_i && reg_addr_i == WOL_IDX_IMR) imr7_q <= reg_wdata_i[7];
      if (reg_wr_i && par_a) par_q[reg_addr_i[2:0]] <= reg_wdata_i;
      age_q  <= cause ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      clr_q  <= (ncr_w || led_chg || reg_wr_i && reg_addr_i == WOL_IDX_WST) ? 4'h0 :
                clr_q + {3'h0, clr_q != 4'hF};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_par_read: assert property (
    reg_rd_i && par_a |=> reg_rdata_o == exp_q) else $error("station address read wrong");
  a_imr_read: assert property (
    reg_rd_i && reg_addr_i == WOL_IDX_IMR |=> reg_rdata_o[7] == $past(imr7_q))
    else $error("pointer auto return bit read wrong");
  a_wcr_read: assert property (
    reg_rd_i && reg_addr_i == WOL_IDX_WCR |=> reg_rdata_o[5:3] == $past(wcr_q))
    else $error("wake enable bits read wrong");
  a_wake_needs_en: assert property ((!ncr6_q)[*3] |-> !wake_o)
    else $error("wake without global enable");
  a_wake_hold: assert property ($fell(wake_o) |-> clr_q <= 4'h6)
    else $error("wake dropped without a clear");
  a_wake_cause: assert property ($rose(wake_o) |-> age_q <= 4'h8)
    else $error("wake rose without a cause");
  a_led_route: assert property (routed[*5] |-> !wake_o)
    else $error("wake pin active while routed to LED");
  a_led_pass: assert property (
    (!routed)[*5] |-> second_led_output_o == $past(second_led_src_i))
    else $error("LED output not following its source");
  c_wake_rise: cover property ($rose(wake_o));
  c_wake_fall: cover property ($fell(wake_o));
  c_led_wake: cover property (routed && second_led_output_o);
endmodule
bind wol_detect wol_detect_checker u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .rx_valid_i(rx_valid_i), .rx_eof_i(rx_eof_i),
  .phy_link_i(phy_link_i), .led_mode_i(led_mode_i), .bus16_mode_i(bus16_mode_i),
  .second_led_src_i(second_led_src_i), .wake_o(wake_o),
  .second_led_output_o(second_led_output_o)
);
`default_nettype wire

// >>> wol_pkg.sv
// Purpose: Shared constants for the wake-on-LAN detector.
// Assumes: Byte-wide register port with 8-bit register indexes.
// Notes:   Sample memory is 16 KiB seen as 4096 words of 32 bits.
package wol_pkg;

  // Register indexes.
  localparam logic [7:0] WOL_IDX_NCR  = 8'h00;
  localparam logic [7:0] WOL_IDX_RCR  = 8'h05;
  localparam logic [7:0] WOL_IDX_WCR  = 8'h0F;
  localparam logic [7:0] WOL_IDX_PAR0 = 8'h10;
  localparam logic [7:0] WOL_IDX_PAR5 = 8'h15;
  localparam logic [7:0] WOL_IDX_WST  = 8'h30;
  localparam logic [7:0] WOL_IDX_MWC  = 8'hF8;
  localparam logic [7:0] WOL_IDX_WPL  = 8'hFA;
  localparam logic [7:0] WOL_IDX_WPH  = 8'hFB;
  localparam logic [7:0] WOL_IDX_IMR  = 8'hFF;

  // Field positions.
  localparam int WOL_NCR_WAKE_EN   = 6;
  localparam int WOL_RCR_RX_EN     = 0;
  localparam int WOL_WCR_MAGIC_EN  = 3;
  localparam int WOL_WCR_SAMPLE_EN = 4;
  localparam int WOL_WCR_LINK_EN   = 5;
  localparam int WOL_EVT_MAGIC     = 0;
  localparam int WOL_EVT_SAMPLE    = 1;
  localparam int WOL_EVT_LINK      = 2;

  // Reset values.
  localparam logic [7:0] WOL_RST_BYTE = 8'h00;
  localparam logic [7:0] WOL_RST_IMR  = 8'h80;

  // Magic packet geometry.
  localparam logic [7:0] WOL_SYNC_BYTE  = 8'hFF;
  localparam logic [2:0] WOL_SYNC_LAST  = 3'h5;
  localparam logic [2:0] WOL_ADDR_LAST  = 3'h5;
  localparam logic [3:0] WOL_COPY_LAST  = 4'hF;

  // Sample frame geometry, condition codes and the LED wake mode.
  localparam int          WOL_NPKT       = 6;
  localparam logic [11:0] WOL_PKT_BYTES  = 12'h800;
  localparam logic [11:0] WOL_COND_WORD  = 12'h800;
  localparam logic [1:0]  WOL_EVEN_UNIT  = 2'h2;
  localparam logic [1:0]  WOL_COND_EQUAL = 2'h2;
  localparam logic [1:0]  WOL_COND_STOP  = 2'h3;
  localparam logic [1:0]  WOL_LED_WAKE   = 2'h2;

  typedef enum logic [0:0] {
    WOL_MG_HUNT = 1'b0,
    WOL_MG_ADDR = 1'b1
  } wol_magic_e;

endpackage

// >>> wol_rx_src.sv
// Purpose: Receive path model that hands whole frames to the detector.
// Assumes: One byte per cycle inside a frame.
// Notes:   Idle data show the inverse of the last byte, never a stale value.
`timescale 1ns/10ps
`default_nettype none
module wol_rx_src (
  input  wire logic       core_clk_i,
  output logic            rx_valid_o,
  output logic            rx_sof_o,
  output logic            rx_eof_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_bcast_o,
  output logic            rx_ok_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_sof_o   = 1'b0;
    rx_eof_o   = 1'b0;
    rx_data_o  = 8'hA5;
    rx_bcast_o = 1'b0;
    rx_ok_o    = 1'b0;
  end
  task automatic send(input logic [7:0] f[$], input logic bc, input logic ok);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge core_clk_i);
      rx_valid_o <= 1'b1;
      rx_sof_o   <= i == 0;
      rx_eof_o   <= i == f.size() - 1;
      rx_data_o  <= f[i];
      rx_bcast_o <= bc;
      rx_ok_o    <= ok;
    end
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    rx_sof_o   <= 1'b0;
    rx_eof_o   <= 1'b0;
    rx_data_o  <= ~rx_data_o;
    rx_bcast_o <= ~bc;
    rx_ok_o    <= ~ok;
  endtask
endmodule
`default_nettype wire

// >>> wol_sram.sv
// Purpose: Pattern memory with one byte-lane write port and two read ports.
// Assumes: Contents are not reset; software loads them before use.
// Notes:   Read data come out of registers one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module wol_sram (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wr_en_i,
  input  wire logic [11:0] wr_word_i,
  input  wire logic [1:0]  wr_lane_i,
  input  wire logic [7:0]  wr_byte_i,
  input  wire logic [11:0] ra_addr_i,
  output logic      [31:0] ra_data_o,
  input  wire logic [11:0] rb_addr_i,
  output logic      [31:0] rb_data_o
);

  logic [31:0] mem [0:4095];

  // The array cannot sit in a packed struct at this size, so it stands alone.
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_word_i][8*wr_lane_i +: 8] <= wr_byte_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ra_data_o <= 32'h0000_0000;
      rb_data_o <= 32'h0000_0000;
    end else begin
      ra_data_o <= mem[ra_addr_i];
      rb_data_o <= mem[rb_addr_i];
    end
  end

endmodule
`default_nettype wire
